// ==== hdl/tws_slave_rx.sv ====
/*
  Slave receiver of a byte-oriented two-wire serial interface with its
  register file, interrupt status/mask and sleep wake-up.
  Assumes open-drain pins resolved outside, a same-clock master block
  that reports lost arbitration and takes the start request pulse, and
  a power controller that raises sleep_i in the clock-stopped modes.
*/
`timescale 1ns/1ps
// Functional notes
// - Upper seven bits address; LSB enables general call
// - Write direction bit selects slave receive
// - Own address write sets flag and status
// - Lost arbitration entry reports 0x68 or 0x78
// - Acknowledge enable cleared gives NACK next byte
// - Without acknowledge enable, addresses ignored, bus monitored
// - Sleeping device still acknowledges address via bus clock
// - Address in sleep wakes part, clock held
// - Data register undefined after clock-stopped sleep wake
// - 0x60 own address; next byte per enable
// - 0x68 arbitration lost then own address
// - 0x70 general call acknowledged
// - 0x78 arbitration lost then general call
// - 0x80 data acknowledged; software reads, picks ACK
// - 0x88 NACK; clear returns unaddressed, optional start
module tws_slave_rx
  import tws_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_o,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic              arb_lost_i,
  input  wire logic              sleep_i,
  output logic                   wake_o,
  output logic                   start_go_o,
  output logic                   irq_o
);

  function automatic logic hit_reg(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    hit_reg = (a == off);
  endfunction

  tws_pins_t  lvl;
  tws_pins_t  rise;
  tws_pins_t  fall;
  tws_state_t state_q;
  tws_ctrl_t  ctrl_q;
  logic [7:0] own_q;
  logic [7:0] data_q;
  logic [7:0] code_q;
  logic [1:0] presc_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic       gc_q;
  logic       nak_q;
  logic       arb_q;
  logic       busy_q;
  logic       pend_q;
  logic       go_q;
  logic       wake_q;
  logic       scl_oe_q;
  logic       sda_oe_q;
  logic       low_q;
  logic       irq_q;
  logic [7:0] rdata_q;
  logic [IRQ_W-1:0] ist_q;
  logic [IRQ_W-1:0] imsk_q;

  logic       start_det;
  logic       stop_det;
  logic       byte_done;
  logic       match_own;
  logic       match_gc;
  logic       addr_hit;
  logic       flag_clr;
  logic       ev_set;
  logic [7:0] ev_code;
  logic [IRQ_W-1:0] ist_set;

  tws_sync u_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .pins_i  ('{scl: scl_i, sda: sda_i}),
    .level_o (lvl),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  assign start_det = fall.sda & lvl.scl;
  assign stop_det  = rise.sda & lvl.scl;
  assign byte_done = fall.scl & (cnt_q == BITS_PER_BYTE);

  assign match_own = (shift_q[7:1] == own_q[7:1]);
  assign match_gc  = (shift_q[7:1] == GEN_CALL_ADDR) & own_q[0];
  // Read direction belongs to the transmitter, which is not built here
  assign addr_hit  = ctrl_q.iface_enable & ctrl_q.acknowledge_enable
                   & (match_own | match_gc) & ~shift_q[0];

  assign flag_clr = reg_wr_i & hit_reg(reg_addr_i, REG_CTRL)
                  & reg_wdata_i[7];

  // Events that raise the interface flag and their status codes
  always_comb begin
    ev_set  = 1'b0;
    ev_code = ST_NONE;
    if (state_q == S_ACKA && fall.scl) begin
      ev_set = 1'b1;
      unique case ({gc_q, arb_q})
        2'b00: ev_code = ST_SLAW;
        2'b01: ev_code = ST_ARB_SLAW;
        2'b10: ev_code = ST_GCA;
        2'b11: ev_code = ST_ARB_GCA;
      endcase
    end else if (state_q == S_ACKD && fall.scl) begin
      ev_set = 1'b1;
      unique case ({gc_q, nak_q})
        2'b00: ev_code = ST_DAT_ACK;
        2'b01: ev_code = ST_DAT_NAK;
        2'b10: ev_code = ST_GDAT_ACK;
        2'b11: ev_code = ST_GDAT_NAK;
      endcase
    end else if (state_q == S_DATA && (start_det | stop_det)) begin
      ev_set  = 1'b1;
      ev_code = ST_STOP;
    end
  end

  // Bus-side state machine
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
      shift_q <= '0;
      gc_q    <= 1'b0;
      nak_q   <= 1'b0;
    end else if (!ctrl_q.iface_enable) begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
    end else if (start_det) begin
      state_q <= S_ADDR;
      cnt_q   <= '0;
    end else if (stop_det) begin
      state_q <= S_IDLE;
    end else begin
      if (rise.scl && (state_q == S_ADDR || state_q == S_DATA)) begin
        shift_q <= {shift_q[6:0], lvl.sda};
        cnt_q   <= cnt_q + 4'h1;
      end
      unique case (state_q)
        S_IDLE, S_SKIP: ;
        S_ADDR: begin
          if (byte_done) begin
            if (addr_hit) begin
              state_q <= S_ACKA;
              gc_q    <= ~match_own;
            end else begin
              state_q <= S_SKIP;
            end
          end
        end
        S_ACKA: begin
          if (fall.scl) begin
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (!ctrl_q.iface_interrupt_flag) begin
            cnt_q   <= '0;
            // After a NACK the slave drops back to unaddressed
            state_q <= nak_q ? S_IDLE : S_DATA;
            nak_q   <= 1'b0;
          end
        end
        S_DATA: begin
          if (byte_done) begin
            state_q <= S_ACKD;
            nak_q   <= ~ctrl_q.acknowledge_enable;
          end
        end
        S_ACKD: begin
          if (fall.scl) begin
            state_q <= S_WAIT;
          end
        end
      endcase
    end
  end

  // Pin drive: acknowledge on SDA, stretch on SCL
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      low_q    <= 1'b0;
    end else begin
      low_q <= 1'b0;
      if (!ctrl_q.iface_enable || start_det || stop_det) begin
        sda_oe_q <= 1'b0;
      end else if (state_q == S_ADDR && byte_done && addr_hit) begin
        sda_oe_q <= 1'b1;
      end else if (state_q == S_DATA && byte_done) begin
        sda_oe_q <= ctrl_q.acknowledge_enable;
      end else if (fall.scl) begin
        sda_oe_q <= 1'b0;
      end
      // Hold SCL low from an address or data flag edge until software clears it
      scl_oe_q <= ctrl_q.iface_enable & ~stop_det
                & ((ev_set & ev_code != ST_STOP)
                | (scl_oe_q & ctrl_q.iface_interrupt_flag & ~flag_clr));
    end
  end

  // Control, own address, status and data registers
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ctrl_q  <= CTRL_RST;
      own_q   <= OWN_RST;
      data_q  <= DATA_RST;
      code_q  <= ST_NONE;
      presc_q <= '0;
    end else begin
      if (reg_wr_i && hit_reg(reg_addr_i, REG_CTRL)) begin
        ctrl_q.acknowledge_enable     <= reg_wdata_i[6];
        ctrl_q.start_request          <= reg_wdata_i[5];
        ctrl_q.stop_request           <= reg_wdata_i[4];
        ctrl_q.iface_enable           <= reg_wdata_i[2];
        ctrl_q.iface_interrupt_enable <= reg_wdata_i[0];
      end
      if (reg_wr_i && hit_reg(reg_addr_i, REG_OWN)) begin
        own_q <= reg_wdata_i;
      end
      if (reg_wr_i && hit_reg(reg_addr_i, REG_STAT)) begin
        presc_q <= reg_wdata_i[1:0] & PRESC_MASK;
      end
      // A write while the flag is low collides with the transfer
      if (reg_wr_i && hit_reg(reg_addr_i, REG_DATA)) begin
        ctrl_q.write_collision_flag <= ~ctrl_q.iface_interrupt_flag;
        if (ctrl_q.iface_interrupt_flag) begin
          data_q <= reg_wdata_i;
        end
      end
      // Only received data bytes and data writes with the flag set load it;
      // an address seen while asleep leaves stale contents behind
      if (state_q == S_DATA && byte_done) begin
        data_q <= shift_q;
      end
      // A new event wins over a clear in the same cycle
      if (ev_set) begin
        ctrl_q.iface_interrupt_flag <= 1'b1;
        code_q                      <= ev_code;
      end else if (flag_clr) begin
        ctrl_q.iface_interrupt_flag <= 1'b0;
        code_q                      <= ST_NONE;
      end
      ctrl_q.reserved <= 1'b0;
    end
  end

  // Lost arbitration, bus busy and the deferred start request
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      arb_q  <= 1'b0;
      busy_q <= 1'b0;
      pend_q <= 1'b0;
      go_q   <= 1'b0;
    end else begin
      if (arb_lost_i) begin
        arb_q <= 1'b1;
      end else if (stop_det || ev_set) begin
        arb_q <= 1'b0;
      end
      if (start_det) begin
        busy_q <= 1'b1;
      end else if (stop_det) begin
        busy_q <= 1'b0;
      end
      go_q <= 1'b0;
      if (state_q == S_WAIT && nak_q && flag_clr
          && reg_wdata_i[5]) begin
        pend_q <= 1'b1;
      end else if (pend_q && !busy_q && !start_det) begin
        pend_q <= 1'b0;
        go_q   <= 1'b1;
      end
    end
  end

  // Wake the part when addressed in a clock-stopped sleep mode
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= sleep_i & (state_q == S_ADDR) & byte_done
              & addr_hit;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  assign ist_set[IB_FLAG] = ev_set;
  assign ist_set[IB_WAKE] = wake_q;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ist_q  <= '0;
      imsk_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      if (reg_wr_i && hit_reg(reg_addr_i, REG_IMSK)) begin
        imsk_q <= reg_wdata_i[IRQ_W-1:0];
      end
      if (reg_wr_i && hit_reg(reg_addr_i, REG_IST)) begin
        ist_q <= (ist_q & ~reg_wdata_i[IRQ_W-1:0]) | ist_set;
      end else begin
        ist_q <= ist_q | ist_set;
      end
      irq_q <= |(ist_q & imsk_q);
    end
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_q <= '0;
    end else if (!reg_rd_i) begin
      rdata_q <= '0;
    end else begin
      unique case (reg_addr_i)
        REG_OWN:  rdata_q <= own_q;
        REG_CTRL: rdata_q <= ctrl_q;
        REG_STAT: rdata_q <= {code_q[7:2], presc_q};
        REG_DATA: rdata_q <= data_q;
        REG_IST:  rdata_q <= 8'(ist_q);
        REG_IMSK: rdata_q <= 8'(imsk_q);
        default:  rdata_q <= '0;
      endcase
    end
  end

  assign reg_rdata_o = rdata_q;
  assign scl_o       = low_q;
  assign sda_o       = low_q;
  assign scl_oe_o    = scl_oe_q;
  assign sda_oe_o    = sda_oe_q;
  assign wake_o      = wake_q;
  assign start_go_o  = go_q;
  assign irq_o       = irq_q;

endmodule

// ==== hdl/tws_pkg.sv ====
/*
  Shared constants and types of the two-wire slave receiver.
  Assumes a single 20 MHz clock domain and byte-wide registers.
*/
package tws_pkg;

  localparam int ADDR_W = 3;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] REG_OWN  = 3'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL = 3'h1;
  localparam logic [ADDR_W-1:0] REG_STAT = 3'h2;
  localparam logic [ADDR_W-1:0] REG_DATA = 3'h3;
  localparam logic [ADDR_W-1:0] REG_IST  = 3'h4;
  localparam logic [ADDR_W-1:0] REG_IMSK = 3'h5;

  localparam logic [7:0] OWN_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Status codes, prescaler bits zero
  localparam logic [7:0] ST_NONE     = 8'hf8;
  localparam logic [7:0] ST_SLAW     = 8'h60;
  localparam logic [7:0] ST_ARB_SLAW = 8'h68;
  localparam logic [7:0] ST_GCA      = 8'h70;
  localparam logic [7:0] ST_ARB_GCA  = 8'h78;
  localparam logic [7:0] ST_DAT_ACK  = 8'h80;
  localparam logic [7:0] ST_DAT_NAK  = 8'h88;
  localparam logic [7:0] ST_GDAT_ACK = 8'h90;
  localparam logic [7:0] ST_GDAT_NAK = 8'h98;
  localparam logic [7:0] ST_STOP     = 8'ha0;
  localparam logic [1:0] PRESC_MASK  = 2'h3;

  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Interrupt status / mask bit positions
  localparam int IRQ_W   = 2;
  localparam int IB_FLAG = 0;
  localparam int IB_WAKE = 1;

  typedef struct packed {
    logic iface_interrupt_flag;
    logic acknowledge_enable;
    logic start_request;
    logic stop_request;
    logic write_collision_flag;
    logic iface_enable;
    logic reserved;
    logic iface_interrupt_enable;
  } tws_ctrl_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } tws_pins_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_ACKA = 3'h3,
    S_WAIT = 3'h2,
    S_DATA = 3'h6,
    S_ACKD = 3'h7,
    S_SKIP = 3'h4
  } tws_state_t;

endpackage

// ==== hdl/tws_sync.sv ====
/*
  Two-flop synchroniser with edge detection for the bus pins.
  Assumes the pins are asynchronous to clock_i; edges are judged only
  from the second flop onward.
*/
`timescale 1ns/1ps
module tws_sync
  import tws_pkg::*;
(
  input  wire logic      clock_i,
  input  wire logic      rstn_i,
  input  wire tws_pins_t pins_i,
  output tws_pins_t      level_o,
  output tws_pins_t      rise_o,
  output tws_pins_t      fall_o
);

  tws_pins_t meta_q;
  tws_pins_t sync_q;
  tws_pins_t last_q;

  // Idle bus level is high, so reset to ones to avoid a false edge
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      meta_q <= '1;
      sync_q <= '1;
      last_q <= '1;
    end else begin
      meta_q <= pins_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q;
  assign fall_o  = ~sync_q & last_q;

endmodule

// ==== tb/tws_sva.sv ====
/*
  Port checker for the two-wire slave receiver.
  Assumes binding to tws_slave_rx; sees only its ports.
*/
`timescale 1ns/1ps
module tws_sva
  import tws_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              rstn_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic              scl_o,
  input wire logic              scl_oe_o,
  input wire logic              sda_o,
  input wire logic              sda_oe_o,
  input wire logic              sleep_i,
  input wire logic              wake_o,
  input wire logic              start_go_o,
  input wire logic              irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  a_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  // Only a control write (flag clear or disable) may let the clock go
  a_stretch_hold: assert property (
    scl_oe_o && !(reg_wr_i && reg_addr_i == REG_CTRL) |=> scl_oe_o)
    else $error("clock stretch released early");
  // The output is one register behind status and mask
  a_irq_masked: assert property (
    reg_wr_i && reg_addr_i == REG_IMSK && reg_wdata_i[1:0] == 2'h0
    |=> ##1 !irq_o)
    else $error("interrupt while fully masked");
  a_od_low: assert property (
    scl_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain pin driven high");
  a_start_pulse: assert property (
    start_go_o |=> !start_go_o)
    else $error("start go longer than one cycle");
  a_wake_cause: assert property (
    wake_o |-> $past(sleep_i) && sda_oe_o)
    else $error("wake without acked address in sleep");
  a_wake_hold: assert property (
    wake_o |-> ##[4:14] scl_oe_o)
    else $error("clock not held after wake");
  a_ack_span: assert property (
    $rose(sda_oe_o) |-> sda_oe_o [*6] ##[1:6] !sda_oe_o)
    else $error("acknowledge length wrong");
endmodule

bind tws_slave_rx tws_sva u_sva (
  .clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sleep_i(sleep_i),
  .wake_o(wake_o), .start_go_o(start_go_o), .irq_o(irq_o));

// ==== tb/tws_i2c_master.sv ====
/*
  Behavioural bus master transmitter, 400 ns bit period.
  Assumes pulled-up wires; outputs high mean released.
*/
`timescale 1ns/1ps
module tws_i2c_master (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start;
    sda_o = 1'b0;
    #200 scl_o = 1'b0;
    #100;
  endtask
  task automatic stop;
    sda_o = 1'b0;
    #100 scl_o = 1'b1;
    wait (scl_i);
    #200 sda_o = 1'b1;
    #300;
  endtask
  // Waits while the slave stretches the clock low
  task automatic clk_bit(input logic b, output logic s);
    sda_o = b;
    #100 scl_o = 1'b1;
    wait (scl_i);
    #100 s = sda_i;
    #100 scl_o = 1'b0;
    #100;
  endtask
  task automatic send(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, nak);
  endtask
endmodule

// ==== tb/tws_slave_rx_tb.sv ====
/*
  Self-checking bench of the two-wire slave receiver.
  Assumes the master model drives the bus; the bench is software.
*/
`timescale 1ns/1ps
module tws_slave_rx_tb
  import tws_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd_s = 1'b0;
  logic arb = 1'b0, slp = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00, rdata, v, d;
  logic scl_oe, sda_oe, wake, sgo, irq, scl_m, sda_m, ak;
  logic [6:0] a;
  logic [15:0] seed = 16'h082b;
  int bad_count = 0, tests_run = 0, wake_n = 0, sgo_n = 0;
  wire scl = scl_m & ~scl_oe;
  wire sda = sda_m & ~sda_oe;

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (wake === 1'b1) wake_n++;
    if (sgo === 1'b1) sgo_n++;
  end

  tws_slave_rx dut (.clock_i(clk), .rstn_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd_s),
    .reg_rdata_o(rdata), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .arb_lost_i(arb),
    .sleep_i(slp), .wake_o(wake), .start_go_o(sgo), .irq_o(irq));
  tws_i2c_master m (.scl_i(scl), .sda_i(sda), .scl_o(scl_m),
    .sda_o(sda_m));

  task final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task rnd(output logic [7:0] r);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    r = seed[7:0];
  endtask
  task wr_reg(input logic [ADDR_W-1:0] ra, input logic [7:0] rv);
    @(posedge clk);
    addr <= ra;
    wdata <= rv;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [ADDR_W-1:0] ra, output logic [7:0] rv);
    @(posedge clk);
    addr <= ra;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 rv = rdata;
  endtask
  // Gc adds 0x10; arbitration loss or a refused byte adds 0x08
  function automatic logic [7:0] st_code(input logic dat, input logic gc,
                                         input logic sub);
    return (dat ? 8'h80 : 8'h60) | {3'h0, gc, sub, 3'h0};
  endfunction
  task byte_chk(input logic [7:0] b, input logic nak, input logic [7:0] st);
    m.send(b, ak);
    chk(ak, nak);
    for (int i = 0; i < 6; i++) begin
      rd_reg(REG_CTRL, v);
      if (v[7]) break;
    end
    rd_reg(REG_STAT, v);
    chk({v[7:2], 2'h0}, st);
  endtask
  // Refuse one byte, then leave the bus
  task finish(input logic gc, input logic [7:0] cv);
    wr_reg(REG_CTRL, 8'h84);
    rnd(d);
    byte_chk(d, 1'b1, st_code(1'b1, gc, 1'b1));
    wr_reg(REG_CTRL, cv);
    m.stop;
  endtask

  initial begin
    #2_000_000;
    bad_count++;
    final_report;
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(REG_OWN, v);
    chk(v, OWN_RST);
    rd_reg(REG_CTRL, v);
    chk(v, CTRL_RST);
    rd_reg(REG_STAT, v);
    chk(v, ST_NONE);
    wr_reg(3'h7, 8'hff);
    rd_reg(3'h6, v);
    chk(v, 8'h00);
    wr_reg(REG_DATA, 8'h5a);
    rd_reg(REG_CTRL, v);
    chk(v[3], 1'b1);
    rnd(d);
    a = {d[6:1], 1'b1};
    wr_reg(REG_STAT, 8'h03);
    wr_reg(REG_IMSK, 8'h03);
    wr_reg(REG_OWN, {a, 1'b1});
    wr_reg(REG_CTRL, 8'h44);
    for (int k = 0; k < 4; k++) begin
      if (k[1]) begin
        @(posedge clk) arb <= 1'b1;
        @(posedge clk) arb <= 1'b0;
      end
      m.start;
      byte_chk(k[0] ? 8'h00 : {a, 1'b0}, 1'b0,
               st_code(1'b0, k[0], k[1]));
      wr_reg(REG_CTRL, 8'hc4);
      rnd(d);
      byte_chk(d, 1'b0, st_code(1'b1, k[0], 1'b0));
      rd_reg(REG_DATA, v);
      chk(v, d);
      finish(k[0], k == 0 ? 8'he4 : 8'hc4);
    end
    chk(sgo_n, 1);
    chk(irq, 1'b1);
    wr_reg(REG_IMSK, 8'h00);
    @(posedge clk) #1 chk(irq, 1'b0);
    wr_reg(REG_IST, 8'h03);
    wr_reg(REG_IMSK, 8'h03);
    @(posedge clk) #1 chk(irq, 1'b0);
    for (int j = 0; j < 2; j++) begin
      m.start;
      byte_chk(j ? {a, 1'b1} : {a ^ 7'h02, 1'b0}, 1'b1, ST_NONE);
      m.stop;
    end
    wr_reg(REG_OWN, {a, 1'b0});
    m.start;
    byte_chk(8'h00, 1'b1, ST_NONE);
    m.stop;
    wr_reg(REG_CTRL, 8'h04);
    m.start;
    byte_chk({a, 1'b0}, 1'b1, ST_NONE);
    m.stop;
    wr_reg(REG_CTRL, 8'h44);
    slp <= 1'b1;
    m.start;
    byte_chk({a, 1'b0}, 1'b0, ST_SLAW);
    @(posedge clk) slp <= 1'b0;
    chk(wake_n, 1);
    rd_reg(REG_IST, v);
    chk(v[1], 1'b1);
    finish(1'b0, 8'hc4);
    final_report;
  end
endmodule
